// ===== hdl/mrt_pkg.sv
// constants, types and carriers for the mii/rmii transmit and clocking block
// assumes one system clock of 100 mhz and a wishbone classic register bus
package mrt_pkg;

  // ==========================================================================
  // clock rates
  // ==========================================================================
  localparam int unsigned CLK_HZ = 100_000_000;         // system clock input
  localparam int unsigned MII_FAST_HZ = 25_000_000;     // 100 mbps nibble clock
  localparam int unsigned MII_SLOW_HZ = 2_500_000;      // 10 mbps nibble clock
  localparam int unsigned RMII_REF_MAX_HZ = 50_000_000; // top rate of the reference clock
  // half periods of the generated mii clock, in system clock cycles
  localparam logic [4:0] FAST_HALF_CYC = 5'(CLK_HZ / (2 * MII_FAST_HZ));
  localparam logic [4:0] SLOW_HALF_CYC = 5'(CLK_HZ / (2 * MII_SLOW_HZ));
  // reference clock edges per dibit at 10 mbps in rmii
  localparam logic [3:0] RMII_SLOW_HOLD = 4'ha;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_DIV = 8'h08;
  localparam logic [7:0] ADR_FRAMES = 8'h0c;

  // ctrl fields
  localparam int unsigned CTRL_ENABLE_BIT = 0; // allow frames to start
  localparam int unsigned CTRL_RMII_BIT = 1;   // 1 rmii, 0 mii
  localparam int unsigned CTRL_DCE_BIT = 2;    // 1 device makes the mii clocks
  localparam int unsigned CTRL_FAST_BIT = 3;   // 1 100 mbps, 0 10 mbps
  localparam logic [3:0] CTRL_RESET = 4'h8;
  // status fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_UNDERRUN_BIT = 1; // sticky, write one to clear
  // divider of the reference clock output, half period in system cycles
  localparam logic [7:0] DIV_RESET = 8'h01;

  // ==========================================================================
  // framing
  // ==========================================================================
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [2:0] PREAMBLE_LAST = 3'h6;  // index of the last 0x55 byte
  localparam logic [5:0] IPG_MII_SYMS = 6'h18;  // 12 bytes of nibbles
  localparam logic [5:0] IPG_RMII_SYMS = 6'h30; // 12 bytes of dibits

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_DATA = 2'b11,
    ST_GAP = 2'b10
  } mrt_state_e;

  // frame byte stream from the user side
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } mrt_stream_s;

  // transmit pins toward the phy
  typedef struct packed {
    logic tx_en;
    logic [3:0] txd;
  } mrt_phy_tx_s;

endpackage

// ===== hdl/mrt_pin_sync.sv
// three-stage synchroniser for one pin, with a filtered level and a rise pulse
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module mrt_pin_sync (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pin,
  output logic level,
  output logic rise
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [2:0] stage; // stage[0] is read only by stage[1]
    logic level;       // filtered level
    logic rise;        // one-cycle rise pulse
  } mrt_sync_s;

  mrt_sync_s st_r;
  mrt_sync_s st_nxt;

  // a change counts only once stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage = {st_r.stage[1:0], pin};
    st_nxt.rise = 1'b0;
    if (st_r.stage[1] == st_r.stage[2]) begin
      st_nxt.level = st_r.stage[2];
      st_nxt.rise = st_r.stage[2] & ~st_r.level;
    end
  end

  // register the copy
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.level;
  assign rise = st_r.rise;

endmodule
`default_nettype wire

// ===== hdl/mrt_tx_port.sv
// transmit side of the mii/rmii phy port, its clocks and a wishbone slave
// assumes ref_clk is the 100 mhz system clock input; phy clocks are sampled
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module mrt_tx_port (
  input wire logic ref_clk,
  input wire logic resetn,
  // wishbone classic slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // frame bytes in
  input wire mrt_pkg::mrt_stream_s tx_in,
  output logic tx_in_ready,
  // phy side
  input wire logic ref_clk_in,
  output logic divided_reference_clock_output,
  input wire logic tx_clk_i,
  output logic tx_clk_o,
  output logic tx_clk_oe,
  output logic rx_clk_o,
  output logic rx_clk_oe,
  output mrt_pkg::mrt_phy_tx_s phy_tx
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [3:0] ctrl;         // control register
    logic [7:0] div;          // reference output half period
    logic underrun;           // sticky underrun flag
    logic [15:0] frames;      // frames sent
    logic ack;                // bus answer
    logic [31:0] rdata;       // registered read data
    logic [7:0] refo_cnt;     // reference output divider
    logic refo;               // reference output level
    logic [4:0] dce_cnt;      // generated mii clock divider
    logic dce_clk;            // generated mii clock level
    logic [3:0] hold_cnt;     // rmii 10 mbps edge counter
    mrt_pkg::mrt_state_e state;
    logic [7:0] sh;           // byte being shifted out
    logic [1:0] sym_left;     // symbols left in sh
    logic last_byte;          // sh holds the frame's last byte
    logic [2:0] pre_cnt;      // preamble byte index
    logic [5:0] gap_cnt;      // idle symbols after a frame
    mrt_pkg::mrt_phy_tx_s tx; // pins
  } mrt_core_s;

  mrt_core_s st_r;
  mrt_core_s st_nxt;

  logic txclk_rise; // phy clock edge, dte
  logic refin_rise; // reference clock input edge, rmii
  logic bus_req;    // new bus access this cycle
  logic take;       // a stream byte is taken this cycle

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  mrt_pin_sync u_sync_txclk (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(tx_clk_i),
    .level(),
    .rise(txclk_rise)
  );

  // reference clock input is sampled; at 100 mhz this only resolves rates well
  // below the 50 mhz ceiling, so fast rmii needs the output looped to it
  mrt_pin_sync u_sync_refin (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(ref_clk_in),
    .level(),
    .rise(refin_rise)
  );

  // ==========================================================================
  // helpers
  // ==========================================================================
  // register select, shared by read and write decode
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  // first symbol of a byte: nibble for mii, dibit for rmii
  function automatic logic [3:0] first_sym(input logic [7:0] b, input logic rmii);
    first_sym = rmii ? {2'h0, b[1:0]} : b[3:0];
  endfunction

  // rest of a byte after its first symbol left
  function automatic logic [7:0] rest(input logic [7:0] b, input logic rmii);
    rest = rmii ? {2'h0, b[7:2]} : {4'h0, b[7:4]};
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic rmii;
    logic dce;
    logic fast;
    logic [4:0] half;
    logic dce_rise;
    logic tick;
    logic load;
    logic [7:0] nb;
    logic [7:0] wr_ctrl;
    logic set_ur;
    st_nxt = st_r;
    rmii = st_r.ctrl[mrt_pkg::CTRL_RMII_BIT];
    dce = st_r.ctrl[mrt_pkg::CTRL_DCE_BIT];
    fast = st_r.ctrl[mrt_pkg::CTRL_FAST_BIT];
    dce_rise = 1'b0;
    tick = 1'b0;
    load = 1'b0;
    nb = mrt_pkg::PREAMBLE_BYTE;
    take = 1'b0;
    wr_ctrl = '0;
    set_ur = 1'b0; // underrun event this cycle
    half = '0;

    if (st_r.refo_cnt + 8'h01 >= st_r.div) begin
      st_nxt.refo_cnt = '0;
      st_nxt.refo = ~st_r.refo;
    end else begin
      st_nxt.refo_cnt = st_r.refo_cnt + 8'h01;
    end

    half = fast ? mrt_pkg::FAST_HALF_CYC : mrt_pkg::SLOW_HALF_CYC;
    if (st_r.dce_cnt + 5'h01 >= half) begin
      st_nxt.dce_cnt = '0;
      st_nxt.dce_clk = ~st_r.dce_clk;
      dce_rise = ~st_r.dce_clk;
    end else begin
      st_nxt.dce_cnt = st_r.dce_cnt + 5'h01;
    end

    // link timing source
    if (rmii) begin
      if (refin_rise) begin
        if (fast) begin
          tick = 1'b1;
        end else begin
          tick = (st_r.hold_cnt == 4'h0);
          st_nxt.hold_cnt = (st_r.hold_cnt + 4'h1 >= mrt_pkg::RMII_SLOW_HOLD) ? 4'h0 : st_r.hold_cnt + 4'h1;
        end
      end
    end else begin
      // phy clock in dte, own in dce
      tick = dce ? dce_rise : txclk_rise;
    end

    // frame sequencer, acts only on link edges
    if (tick) begin
      unique case (st_r.state)
        mrt_pkg::ST_IDLE: begin
          // enable rises with first preamble symbol
          if (st_r.ctrl[mrt_pkg::CTRL_ENABLE_BIT] && tx_in.valid) begin
            load = 1'b1;
            nb = mrt_pkg::PREAMBLE_BYTE;
            st_nxt.pre_cnt = '0;
            st_nxt.last_byte = 1'b0;
            st_nxt.state = mrt_pkg::ST_PRE;
          end
        end
        mrt_pkg::ST_PRE: begin
          if (st_r.sym_left == 2'h0) begin
            if (st_r.pre_cnt == mrt_pkg::PREAMBLE_LAST) begin
              load = 1'b1;
              nb = mrt_pkg::SFD_BYTE;
              st_nxt.state = mrt_pkg::ST_DATA;
            end else begin
              load = 1'b1;
              st_nxt.pre_cnt = st_r.pre_cnt + 3'h1;
            end
          end
        end
        mrt_pkg::ST_DATA: begin
          if (st_r.sym_left == 2'h0) begin
            if (st_r.last_byte) begin
              st_nxt.state = mrt_pkg::ST_GAP;
              st_nxt.gap_cnt = rmii ? mrt_pkg::IPG_RMII_SYMS : mrt_pkg::IPG_MII_SYMS;
              st_nxt.frames = st_r.frames + 16'h0001;
            end else if (tx_in.valid) begin
              load = 1'b1;
              take = 1'b1;
              nb = tx_in.data;
              st_nxt.last_byte = tx_in.last;
            end else begin
              // source ran dry mid frame: cut it short and flag it
              set_ur = 1'b1;
              st_nxt.underrun = 1'b1;
              st_nxt.state = mrt_pkg::ST_GAP;
              st_nxt.gap_cnt = rmii ? mrt_pkg::IPG_RMII_SYMS : mrt_pkg::IPG_MII_SYMS;
            end
          end
        end
        mrt_pkg::ST_GAP: begin
          st_nxt.gap_cnt = st_r.gap_cnt - 6'h01;
          if (st_r.gap_cnt == 6'h01) begin
            st_nxt.state = mrt_pkg::ST_IDLE;
          end
        end
      endcase

      // enable only with a valid symbol
      if (load) begin
        st_nxt.tx.tx_en = 1'b1;
        st_nxt.tx.txd = first_sym(nb, rmii);
        st_nxt.sh = rest(nb, rmii);
        st_nxt.sym_left = rmii ? 2'h3 : 2'h1;
      end else if (st_r.state != mrt_pkg::ST_IDLE && st_r.state != mrt_pkg::ST_GAP &&
                   st_r.sym_left != 2'h0) begin
        st_nxt.tx.tx_en = 1'b1;
        st_nxt.tx.txd = first_sym(st_r.sh, rmii);
        st_nxt.sh = rest(st_r.sh, rmii);
        st_nxt.sym_left = st_r.sym_left - 2'h1;
      end else begin
        st_nxt.tx.tx_en = 1'b0;
        st_nxt.tx.txd = '0;
      end
    end

    // wishbone: one wait state, ack drops the cycle after
    st_nxt.ack = bus_req;
    // writes land at the edge where the master sees ack, while the request still stands
    if (wb_cyc && wb_stb && wb_we && st_r.ack) begin
      if (hit(wb_adr, mrt_pkg::ADR_CTRL) && wb_sel[0]) begin
        wr_ctrl = wb_dat_w[7:0];
        st_nxt.ctrl = wr_ctrl[3:0];
      end
      if (hit(wb_adr, mrt_pkg::ADR_DIV) && wb_sel[0]) begin
        st_nxt.div = wb_dat_w[7:0];
      end
      // clear by writing one; a new underrun this cycle wins
      if (hit(wb_adr, mrt_pkg::ADR_STATUS) && wb_sel[0] && wb_dat_w[mrt_pkg::STAT_UNDERRUN_BIT] &&
          !set_ur) begin
        st_nxt.underrun = 1'b0;
      end
    end

    // read data, unmapped reads return zero
    st_nxt.rdata = '0;
    if (bus_req && !wb_we) begin
      if (hit(wb_adr, mrt_pkg::ADR_CTRL)) begin
        st_nxt.rdata = {28'h0, st_r.ctrl};
      end else if (hit(wb_adr, mrt_pkg::ADR_STATUS)) begin
        st_nxt.rdata = {28'h0, st_r.state, st_r.underrun, st_r.state != mrt_pkg::ST_IDLE};
      end else if (hit(wb_adr, mrt_pkg::ADR_DIV)) begin
        st_nxt.rdata = {24'h0, st_r.div};
      end else if (hit(wb_adr, mrt_pkg::ADR_FRAMES)) begin
        st_nxt.rdata = {16'h0, st_r.frames};
      end
    end
  end

  // new access only when no answer stands
  assign bus_req = wb_cyc & wb_stb & ~st_r.ack;

  // ==========================================================================
  // register the copy
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.ctrl <= mrt_pkg::CTRL_RESET;
      st_r.div <= mrt_pkg::DIV_RESET;
      st_r.state <= mrt_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign wb_ack = st_r.ack;
  assign wb_dat_r = st_r.rdata;
  assign tx_in_ready = take;
  assign divided_reference_clock_output = st_r.refo;
  assign tx_clk_o = st_r.dce_clk;
  assign rx_clk_o = st_r.dce_clk;
  assign tx_clk_oe = st_r.ctrl[mrt_pkg::CTRL_DCE_BIT] & ~st_r.ctrl[mrt_pkg::CTRL_RMII_BIT];
  assign rx_clk_oe = st_r.ctrl[mrt_pkg::CTRL_DCE_BIT] & ~st_r.ctrl[mrt_pkg::CTRL_RMII_BIT];
  assign phy_tx = st_r.tx;

endmodule
`default_nettype wire

// ===== testbench/mrt_tx_port_sva.sv
// checker for the mrt_tx_port pins and its wishbone slave
// assumes it is bound into mrt_tx_port; one clock, sync reset
`timescale 1ns/100ps
`default_nettype none

module mrt_tx_port_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack,
  input wire logic tx_in_ready,
  input wire logic tx_clk_o,
  input wire logic tx_clk_oe,
  input wire logic rx_clk_o,
  input wire logic rx_clk_oe,
  input wire mrt_pkg::mrt_phy_tx_s phy_tx
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // helpers
  // ==========================================================
  logic last_r; // previous clock level
  logic seen_r; // first half after oe is partial, skip it
  logic [5:0] run_r; // samples at the old level
  // level run counter of the generated clock
  always_ff @(posedge ref_clk) begin
    last_r <= tx_clk_o;
    if (!resetn || !tx_clk_oe) begin
      seen_r <= 1'b0;
      run_r <= 6'h01;
    end else if (tx_clk_o != last_r) begin
      seen_r <= 1'b1;
      run_r <= 6'h01;
    end else if (run_r != 6'h3f) begin
      run_r <= run_r + 6'h01;
    end
  end
  // ==========================================================
  // properties
  // ==========================================================
  property p_ack_next;
    wb_cyc && wb_stb && !wb_ack |=> wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack |=> !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle;
    !wb_ack |-> wb_dat_r == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_oe_pair;
    tx_clk_oe || rx_clk_oe |-> tx_clk_oe && rx_clk_oe && rx_clk_o == tx_clk_o;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("rx and tx clock differ");
  property p_clk_half;
    tx_clk_oe && seen_r && tx_clk_o != last_r |-> run_r == 6'h02 || run_r == 6'h14;
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("bad mii half period");
  property p_pre_first;
    $rose(phy_tx.tx_en) |-> phy_tx.txd[1:0] == 2'b01;
  endproperty
  a_pre_first: assert property (p_pre_first) else $error("enable rose off preamble");
  property p_gap;
    $fell(phy_tx.tx_en) |-> !phy_tx.tx_en [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("gap too short");
  property p_ready_frame;
    tx_in_ready |-> phy_tx.tx_en ##1 !tx_in_ready;
  endproperty
  a_ready_frame: assert property (p_ready_frame) else $error("ready outside frame");
  property p_dce_edge;
    tx_clk_oe && $changed(phy_tx) |-> $rose(tx_clk_o);
  endproperty
  a_dce_edge: assert property (p_dce_edge) else $error("pins moved off clock rise");
endmodule

`default_nettype wire

// ===== testbench/mrt_phy_model.sv
// phy model: makes the link clocks, records symbols while enabled
// assumes tb selects the mode; cap is read hierarchically
`timescale 1ns/100ps
`default_nettype none

module mrt_phy_model (
  input wire logic mode_dte,
  input wire logic mode_rmii,
  input wire logic ref_run,
  input wire logic tx_clk_o,
  input wire logic tx_clk_oe,
  input wire mrt_pkg::mrt_phy_tx_s phy_tx,
  output logic tx_clk_i,
  output logic ref_clk_in
);
  logic [3:0] cap[$]; // symbols seen while enable high
  initial begin
    tx_clk_i = 1'b0;
    ref_clk_in = 1'b0;
  end
  // phy clock 2.5 mhz, stands when unused
  always #200 tx_clk_i = mode_dte ? !tx_clk_i : 1'b0;
  // runs from reset, held low in dte
  always #40 ref_clk_in = ref_run ? !ref_clk_in : 1'b0;
  // dte: sample on phy clock, enable gates
  always @(posedge tx_clk_i) if (phy_tx.tx_en) cap.push_back(phy_tx.txd);
  always @(posedge ref_clk_in) if (mode_rmii && phy_tx.tx_en) cap.push_back(phy_tx.txd);
  // dce: sample mid bit, pins move on the rise
  always @(negedge tx_clk_o) if (tx_clk_oe && phy_tx.tx_en) cap.push_back(phy_tx.txd);
endmodule

`default_nettype wire

// ===== testbench/tb.sv
// bench for mrt_tx_port: registers, divider, frames in five modes
// assumes the phy model in mrt_phy_model.sv and the checker bound below
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic ref_clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, tx_in_ready, ref_in, ref_out;
  logic tx_clk_i, tx_clk_o, tx_clk_oe, rx_clk_o, rx_clk_oe, mode_dte, mode_rmii, ref_run;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  mrt_pkg::mrt_stream_s tx_in;
  mrt_pkg::mrt_phy_tx_s phy_tx;
  int errors, cmp_count, cyc_cnt, f;
  mrt_tx_port u_dut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .tx_in(tx_in), .tx_in_ready(tx_in_ready), .ref_clk_in(ref_in),
    .divided_reference_clock_output(ref_out), .tx_clk_i(tx_clk_i), .tx_clk_o(tx_clk_o),
    .tx_clk_oe(tx_clk_oe), .rx_clk_o(rx_clk_o), .rx_clk_oe(rx_clk_oe), .phy_tx(phy_tx));
  mrt_phy_model u_phy (.mode_dte(mode_dte), .mode_rmii(mode_rmii), .ref_run(ref_run),
    .tx_clk_o(tx_clk_o), .tx_clk_oe(tx_clk_oe), .phy_tx(phy_tx), .tx_clk_i(tx_clk_i),
    .ref_clk_in(ref_in));
  // ==========================================================
  // clock and hang guard
  // ==========================================================
  always #5 ref_clk = !ref_clk;
  // whole run is under 15k cycles, limit well above
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      errors++;
      stop_test();
    end
  end
  // ==========================================================
  // tasks
  // ==========================================================
  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    @(posedge ref_clk);
    while (wb_ack !== 1'b1) @(posedge ref_clk);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // symbol i of a byte, low bits first
  function automatic logic [3:0] sym(input logic [7:0] b, input int i, input logic rm);
    return rm ? {2'b00, b[2*i +: 2]} : b[4*i +: 4];
  endfunction
  // one frame of random payload, checked symbol by symbol
  task automatic frame(input logic [3:0] ctrl, input int rep);
    logic [7:0] d[$];
    logic [3:0] e[$];
    logic [7:0] bt;
    logic [31:0] q;
    int n, k, i;
    n = 1 + $urandom % 4;
    for (k = 0; k < n; k++) d.push_back(8'($urandom));
    for (k = 0; k < 8 + n; k++) begin
      bt = k < 7 ? mrt_pkg::PREAMBLE_BYTE : k == 7 ? mrt_pkg::SFD_BYTE : d[k-8];
      for (i = 0; i < (ctrl[1] ? 4 : 2); i++) repeat (rep) e.push_back(sym(bt, i, ctrl[1]));
    end
    wr(mrt_pkg::ADR_CTRL, {28'h0, ctrl});
    u_phy.cap.delete();
    tx_in.data <= d[0];
    tx_in.last <= n == 1;
    tx_in.valid <= 1'b1;
    k = 0;
    // next byte offered at once, so no underrun
    while (k < n) begin
      @(posedge ref_clk);
      if (tx_in_ready === 1'b1) begin
        k++;
        tx_in.valid <= k < n;
        if (k < n) tx_in.data <= d[k];
        tx_in.last <= k == n - 1;
      end
    end
    do wb(1'b0, mrt_pkg::ADR_STATUS, 32'h0, q); while (q[0] !== 1'b0);
    chk(q, 32'h0);
    chk(u_phy.cap.size(), e.size());
    for (k = 0; k < e.size() && k < u_phy.cap.size(); k++) chk(u_phy.cap[k], e[k]);
    f++;
    rd(mrt_pkg::ADR_FRAMES, f);
  endtask
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    logic [3:0] cm[5] = '{4'hd, 4'h1, 4'hb, 4'h3, 4'h5};
    logic [7:0] dv[4] = '{8'h00, 8'h01, 8'h03, 8'h06};
    logic v;
    logic [31:0] q;
    int k, n;
    ref_clk = 1'b0;
    resetn = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
    wb_sel = 4'hf;
    tx_in = '0;
    {mode_dte, mode_rmii, ref_run} = 3'b001;
    void'($urandom(96));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(mrt_pkg::ADR_CTRL, 32'h8);
    rd(mrt_pkg::ADR_DIV, 32'h1);
    rd(mrt_pkg::ADR_FRAMES, 32'h0);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0);
    // divider: 0 and 1 both give one cycle halves
    for (k = 0; k < 4; k++) begin
      wr(mrt_pkg::ADR_DIV, {24'h0, dv[k]});
      repeat (20) @(posedge ref_clk);
      v = ref_out;
      while (ref_out === v) @(posedge ref_clk);
      n = 0;
      v = ref_out;
      while (ref_out === v) begin
        @(posedge ref_clk);
        n++;
      end
      chk(n, dv[k] < 2 ? 1 : dv[k]);
    end
    // dce fast, dte slow, rmii fast, rmii slow, dce slow
    for (k = 0; k < 5; k++) begin
      mode_dte <= k == 1;
      mode_rmii <= k == 2 || k == 3;
      ref_run <= k != 1;
      frame(cm[k], k == 3 ? 10 : 1);
    end
    // underrun: one byte taken, then the source runs dry; same clock rate as before
    wr(mrt_pkg::ADR_CTRL, 32'h5);
    tx_in.data <= 8'($urandom);
    tx_in.last <= 1'b0;
    tx_in.valid <= 1'b1;
    do @(posedge ref_clk); while (tx_in_ready !== 1'b1);
    tx_in.valid <= 1'b0;
    do wb(1'b0, mrt_pkg::ADR_STATUS, 32'h0, q); while (q[0] !== 1'b0);
    chk(q, 32'h2);
    // write one clears the sticky flag, cut frame is not counted
    wr(mrt_pkg::ADR_STATUS, 32'h2);
    rd(mrt_pkg::ADR_STATUS, 32'h0);
    rd(mrt_pkg::ADR_FRAMES, f);
    resetn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(mrt_pkg::ADR_CTRL, 32'h8);
    rd(mrt_pkg::ADR_FRAMES, 32'h0);
    stop_test();
  end
endmodule

bind mrt_tx_port mrt_tx_port_sva u_sva (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .tx_in_ready(tx_in_ready),
  .tx_clk_o(tx_clk_o), .tx_clk_oe(tx_clk_oe), .rx_clk_o(rx_clk_o), .rx_clk_oe(rx_clk_oe),
  .phy_tx(phy_tx));

`default_nettype wire
